// ---- logic/ddrio_top.sv ----
/*
  DDR SDRAM I/O datapath: memory clock, write launch, read capture, commands.
  Assumes the strobe and data pins are external and sampled by sys_clk,
  which is many times faster than the memory clock built here.
*/
`timescale 1ns/1ps
// Operation
// - data moves twice per memory clock, system clock up to 200 MHz.
// - data on both edges, command and address on one edge only.
// - one active-high write mask per strobe group.
// - wide memories served as independent by-eight strobe groups.
// - check bits travel in a strobe group of their own.
// - command and address launched on the memory clock falling edge.
// - memory clock from output registers; strobe rises with clock rise.
// - received strobe delayed 72 or 90 degrees before capturing data.
// - delayed strobe clocks the capture registers uninverted: rise word on its rise, fall word on its fall.
// - captured words retimed through two further system clock registers.
// - write strobe launched from the 0 degree phase; its enable rises with the data enable.
// - write data and its enable launched a quarter period earlier.
// - write strobe edges centred within each data bit.
module ddrio_top
  import ddrio_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // write request
  input wire logic wr_valid,
  output logic wr_ready_q,
  input wire logic [DQ_W-1:0] wr_rise,
  input wire logic [DQ_W-1:0] wr_fall,
  input wire logic [LANES-1:0] wr_mask_rise,
  input wire logic [LANES-1:0] wr_mask_fall,
  // command request
  input wire logic cmd_valid,
  output logic cmd_ready_q,
  input wire logic [CMD_W-1:0] cmd_in,
  input wire logic [ADDR_W-1:0] addr_in,
  // read control and data
  input wire logic rd_en,
  input wire logic rd_phase_sel,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DQ_W-1:0] rd_rise,
  output logic [DQ_W-1:0] rd_fall,
  output logic rd_overrun_q,
  // memory pins
  output logic mem_ck_q,
  output logic mem_ck_n_q,
  output logic [CMD_W-1:0] cmd_o_q,
  output logic [ADDR_W-1:0] addr_o_q,
  output logic [LANES-1:0] dm_q,
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] dq_o_q,
  output logic [DQ_W-1:0] dq_oe_q,
  input wire logic [LANES-1:0] dqs_i,
  output logic [LANES-1:0] dqs_o_q,
  output logic [LANES-1:0] dqs_oe_q
);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // tap index for the selected strobe shift
  function automatic int rd_tap(input logic sel);
    return sel ? DLY_B - 1 : DLY_A - 1;
  endfunction

  ddrio_wr_type wst_q, wst_d;
  logic [PH_W-1:0] phase_q, phase_d, wcnt_q, wcnt_d;
  logic [DQ_W-1:0] wrise_q, wrise_d, wfall_q, wfall_d;
  logic [LANES-1:0] mrise_q, mrise_d, mfall_q, mfall_d;
  logic [CMD_W-1:0] pcmd_q, pcmd_d, cmd_o_d;
  logic [ADDR_W-1:0] paddr_q, paddr_d, addr_o_d;
  logic pend_q, pend_d, wr_ready_d, cmd_ready_d, mem_ck_d;
  logic [DQ_W-1:0] dq_o_d, dq_oe_d;
  logic [LANES-1:0] dm_d, dqs_o_d, dqs_oe_d;

  // ----------------------------------------
  // memory clock, write launch and commands
  // ----------------------------------------
  // all pin values are a function of the current phase, so every output lags
  // its phase by one edge and the lag is the same for clock, strobe and data
  always_comb begin
    logic burst;
    logic first;
    burst = (wst_q == WR_BURST);
    first = (wcnt_q < WF_DQ_SWITCH);
    phase_d = (phase_q == PH_LAST) ? '0 : phase_q + PH_ONE;
    wst_d = wst_q;
    wcnt_d = wcnt_q;
    wrise_d = wrise_q;
    wfall_d = wfall_q;
    mrise_d = mrise_q;
    mfall_d = mfall_q;
    unique case (wst_q)
      WR_IDLE: begin
        if (wr_valid && wr_ready_q) begin
          wrise_d = wr_rise;
          wfall_d = wr_fall;
          mrise_d = wr_mask_rise;
          mfall_d = wr_mask_fall;
          wst_d = WR_WAIT;
        end
      end
      WR_WAIT: begin
        // decided from the next phase: the burst state itself costs one edge,
        // and without this the strobe would rise one cycle after the clock
        if (phase_d == PH_WR_START) begin
          wst_d = WR_BURST;
          wcnt_d = '0;
        end
      end
      WR_BURST: begin
        wcnt_d = wcnt_q + PH_ONE;
        if (wcnt_q == WF_LAST) begin
          wst_d = WR_IDLE;
        end
      end
    endcase
    wr_ready_d = (wst_d == WR_IDLE);
    mem_ck_d = (phase_q < PH_HALF);
    dq_oe_d = {DQ_W{burst}};
    dq_o_d = burst ? (first ? wrise_q : wfall_q) : '0;
    dm_d = burst ? (first ? mrise_q : mfall_q) : '0;
    dqs_oe_d = {LANES{burst}};
    dqs_o_d = {LANES{burst && wcnt_q >= WF_DQS_RISE && wcnt_q < WF_DQS_FALL}};
    pend_d = pend_q;
    pcmd_d = pcmd_q;
    paddr_d = paddr_q;
    cmd_o_d = cmd_o_q;
    addr_o_d = addr_o_q;
    if (phase_q == PH_CMD_LAUNCH) begin
      cmd_o_d = pend_q ? pcmd_q : CMD_NOP;
      addr_o_d = pend_q ? paddr_q : addr_o_q;
      pend_d = 1'b0;
    end
    if (cmd_valid && cmd_ready_q) begin
      pend_d = 1'b1;
      pcmd_d = cmd_in;
      paddr_d = addr_in;
    end
    cmd_ready_d = !pend_d;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wst_q <= WR_IDLE;
      phase_q <= '0;
      wcnt_q <= '0;
      pend_q <= 1'b0;
      wr_ready_q <= 1'b0;
      cmd_ready_q <= 1'b0;
      mem_ck_q <= 1'b0;
      mem_ck_n_q <= 1'b1;
      cmd_o_q <= CMD_NOP;
      addr_o_q <= '0;
      dq_o_q <= '0;
      dq_oe_q <= '0;
      dm_q <= '0;
      dqs_o_q <= '0;
      dqs_oe_q <= '0;
    end else begin
      wst_q <= wst_d;
      phase_q <= phase_d;
      wcnt_q <= wcnt_d;
      pend_q <= pend_d;
      wr_ready_q <= wr_ready_d;
      cmd_ready_q <= cmd_ready_d;
      mem_ck_q <= mem_ck_d;
      mem_ck_n_q <= !mem_ck_d;
      cmd_o_q <= cmd_o_d;
      addr_o_q <= addr_o_d;
      dq_o_q <= dq_o_d;
      dq_oe_q <= dq_oe_d;
      dm_q <= dm_d;
      dqs_o_q <= dqs_o_d;
      dqs_oe_q <= dqs_oe_d;
    end
    wrise_q <= wrise_d;
    wfall_q <= wfall_d;
    mrise_q <= mrise_d;
    mfall_q <= mfall_d;
    pcmd_q <= pcmd_d;
    paddr_q <= paddr_d;
  end

  // ----------------------------------------
  // read capture
  // ----------------------------------------
  logic [DQ_W-1:0] dq_s1_q, dq_s2_q;
  logic [LANES-1:0] dqs_s1_q, dqs_s2_q, dqs_s3_q, rise_ev, fall_ev, done_q, done_d;
  logic sel_q, rd_armed, all_done, push_q, buf_ready, overrun_d;
  logic [DLY_A-1:0] evr_q [LANES];
  logic [DLY_A-1:0] evr_d [LANES];
  logic [DLY_A-1:0] evf_q [LANES];
  logic [DLY_A-1:0] evf_d [LANES];
  logic cap_r [LANES];
  logic cap_f [LANES];
  logic [LANE_W-1:0] rcap_q [LANES];
  logic [LANE_W-1:0] rcap_d [LANES];
  logic [LANE_W-1:0] prise_q [LANES];
  logic [LANE_W-1:0] prise_d [LANES];
  logic [LANE_W-1:0] pfall_q [LANES];
  logic [LANE_W-1:0] pfall_d [LANES];
  logic [DQ_W-1:0] pr_flat, pf_flat;

  // strobe edges seen after two sync flops; data goes through the same depth
  // edge-aligned strobe
  assign rise_ev = dqs_s2_q & ~dqs_s3_q;
  assign fall_ev = ~dqs_s2_q & dqs_s3_q;
  // a read during a write burst would only see our own strobe
  assign rd_armed = rd_en && (wst_q != WR_BURST);

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    always_comb begin
      evr_d[l] = {evr_q[l][DLY_A-2:0], rise_ev[l]};
      evf_d[l] = {evf_q[l][DLY_A-2:0], fall_ev[l]};
      cap_r[l] = evr_q[l][rd_tap(sel_q)] && rd_armed;
      cap_f[l] = evf_q[l][rd_tap(sel_q)] && rd_armed;
      rcap_d[l] = cap_r[l] ? dq_s2_q[l*LANE_W +: LANE_W] : rcap_q[l];
      prise_d[l] = prise_q[l];
      pfall_d[l] = pfall_q[l];
      if (cap_f[l]) begin
        prise_d[l] = rcap_q[l];
        pfall_d[l] = dq_s2_q[l*LANE_W +: LANE_W];
      end
    end
  end

  // group completion; a new capture wins over the clear
  always_comb begin
    all_done = &done_q;
    for (int l = 0; l < LANES; l++) begin
      done_d[l] = cap_f[l] || (done_q[l] && !all_done);
      pr_flat[l*LANE_W +: LANE_W] = prise_q[l];
      pf_flat[l*LANE_W +: LANE_W] = pfall_q[l];
    end
    overrun_d = rd_overrun_q || (push_q && !buf_ready);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dqs_s1_q <= '0;
      dqs_s2_q <= '0;
      dqs_s3_q <= '0;
      done_q <= '0;
      push_q <= 1'b0;
      sel_q <= 1'b0;
      rd_overrun_q <= 1'b0;
      for (int l = 0; l < LANES; l++) begin
        evr_q[l] <= '0;
        evf_q[l] <= '0;
      end
    end else begin
      dqs_s1_q <= dqs_i;
      dqs_s2_q <= dqs_s1_q;
      dqs_s3_q <= dqs_s2_q;
      done_q <= done_d;
      push_q <= all_done;
      sel_q <= rd_phase_sel;
      rd_overrun_q <= overrun_d;
      evr_q <= evr_d;
      evf_q <= evf_d;
    end
    dq_s1_q <= dq_i;
    dq_s2_q <= dq_s1_q;
    rcap_q <= rcap_d;
    prise_q <= prise_d;
    pfall_q <= pfall_d;
  end

  ddrio_buf #(.W(2 * DQ_W), .DEPTH(BUF_DEPTH)) u_buf (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(push_q),
    .in_ready(buf_ready),
    .in_data({pf_flat, pr_flat}),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data({rd_fall, rd_rise})
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_rise_90;
    (rise_ev[0] && !sel_q && rd_armed) ##1 (!sel_q && rd_armed)[*4];
  endsequence
  sequence s_rise_72;
    (rise_ev[0] && sel_q && rd_armed) ##1 (sel_q && rd_armed)[*3];
  endsequence
  sequence s_fall_90;
    (fall_ev[0] && !sel_q && rd_armed) ##1 (!sel_q && rd_armed)[*4];
  endsequence

  a_ck_period: assert property ($rose(mem_ck_q) |-> ##16 $rose(mem_ck_q))
    else $error("memory clock period not 16 cycles");
  a_cmd_one_edge: assert property ($changed(cmd_o_q) |-> $fell(mem_ck_q))
    else $error("command changed away from clock fall");
  a_dm_idle: assert property (!dq_oe_q[0] |-> dm_q == '0)
    else $error("mask driven outside a write");
  a_cmd_launch: assert property ($changed(addr_o_q) |-> $past(phase_q) == PH_CMD_LAUNCH)
    else $error("address launched at wrong phase");
  a_dqs_ck_align: assert property ($rose(dqs_o_q[0]) |-> $rose(mem_ck_q))
    else $error("strobe rise not with clock rise");
  a_rd_tap_90: assert property (s_rise_90 |-> cap_r[0])
    else $error("rise capture not 4 cycles after edge");
  a_rd_tap_72: assert property (s_rise_72 |-> cap_r[0])
    else $error("rise capture not 3 cycles after edge");
  a_fall_cap: assert property (s_fall_90 |-> cap_f[0])
    else $error("fall capture not 4 cycles after edge");
  a_retime_push: assert property (all_done |=> push_q ##1 !all_done)
    else $error("completed read not pushed");
  a_dqs_enable: assert property ($rose(dq_oe_q[0]) |-> $rose(dqs_oe_q[0]))
    else $error("strobe enable not with data enable");
  a_dq_lead: assert property ($rose(dq_oe_q[0]) |-> ##4 $rose(dqs_o_q[0]))
    else $error("data does not lead strobe by a quarter");
  a_dq_centre: assert property ($fell(dqs_o_q[0]) |-> $stable(dq_o_q)[*4])
    else $error("data moved near strobe fall");
  a_rd_order: assert property (cap_f[0] |=> pfall_q[0] == $past(dq_s2_q[LANE_W-1:0]))
    else $error("fall word not taken at fall capture");

endmodule

// ---- logic/ddrio_pkg.sv ----
/*
  Constants and types shared by the DDR SDRAM I/O datapath.
  Assumes a 200 MHz system clock and a memory clock divided from it.
*/
package ddrio_pkg;

  // ----------------------------------------
  // clocking
  // ----------------------------------------
  localparam int SYS_CLK_MHZ = 200;
  localparam int SYS_PERIOD_PS = 1000000 / SYS_CLK_MHZ;
  localparam int MEM_CK_PERIOD_NS = 80;
  localparam int CK_CYC = MEM_CK_PERIOD_NS * 1000 / SYS_PERIOD_PS;
  localparam int HALF_CYC = CK_CYC / 2;
  localparam int QTR_CYC = CK_CYC / 4;

  // ----------------------------------------
  // read strobe shift, floor to whole cycles
  // ----------------------------------------
  localparam int RD_SHIFT_A_DEG = 90;
  localparam int RD_SHIFT_B_DEG = 72;
  localparam int DLY_A = CK_CYC * RD_SHIFT_A_DEG / 360;
  localparam int DLY_B = CK_CYC * RD_SHIFT_B_DEG / 360;

  // ----------------------------------------
  // widths: four data groups plus one check-bit group
  // ----------------------------------------
  localparam int DATA_GROUPS = 4;
  localparam int ECC_GROUPS = 1;
  localparam int LANES = DATA_GROUPS + ECC_GROUPS;
  localparam int LANE_W = 8;
  localparam int DQ_W = LANES * LANE_W;
  localparam int CMD_W = 3;
  localparam int ADDR_W = 13;
  localparam int PH_W = 4;
  localparam int BUF_DEPTH = 2;

  // ----------------------------------------
  // phase points within one memory clock period
  // ----------------------------------------
  localparam logic [PH_W-1:0] PH_ONE = 4'h1;
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(CK_CYC - 1);
  localparam logic [PH_W-1:0] PH_HALF = PH_W'(HALF_CYC);
  localparam logic [PH_W-1:0] PH_CMD_LAUNCH = PH_W'(HALF_CYC);
  localparam logic [PH_W-1:0] PH_WR_START = PH_W'(CK_CYC - QTR_CYC);
  localparam logic [PH_W-1:0] WF_LAST = PH_W'(CK_CYC - 1);
  localparam logic [PH_W-1:0] WF_DQ_SWITCH = PH_W'(HALF_CYC);
  localparam logic [PH_W-1:0] WF_DQS_RISE = PH_W'(QTR_CYC);
  localparam logic [PH_W-1:0] WF_DQS_FALL = PH_W'(QTR_CYC + HALF_CYC);
  localparam logic [CMD_W-1:0] CMD_NOP = 3'h7;

  typedef enum logic [1:0] {WR_IDLE, WR_WAIT, WR_BURST} ddrio_wr_type;

endpackage

// ---- logic/ddrio_buf.sv ----
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock, synchronous active-high reset; head entry drives the output.
*/
`timescale 1ns/1ps
module ddrio_buf #(
  parameter int W = 80,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [CW-1:0] cnt_q, cnt_d;
  logic valid_d, ready_d;

  // ----------------------------------------
  // shift-down queue: entry 0 is always the head
  // ----------------------------------------
  // outputs come from flops, so valid and ready are recomputed from the next count
  always_comb begin
    logic push;
    logic pop;
    int wr_idx;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_idx = int'(cnt_q) - (pop ? 1 : 0);
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = (pop && i + 1 < DEPTH) ? mem_q[(i + 1) % DEPTH] : mem_q[i];
      if (push && i == wr_idx) begin
        mem_d[i] = in_data;
      end
    end
    cnt_d = CW'(int'(cnt_q) + (push ? 1 : 0) - (pop ? 1 : 0));
    valid_d = (cnt_d != '0);
    ready_d = (int'(cnt_d) < DEPTH);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_q <= '0;
      out_valid <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_valid <= valid_d;
      in_ready <= ready_d;
    end
    mem_q <= mem_d;
  end

  assign out_data = mem_q[0];

endmodule

// ---- dv/ddrio_mem_model.sv ----
/*
  Behavioural DDR memory standing at the pins of the datapath.
  Assumes the bench pulses go to start a read burst; strobe idles low between bursts.
*/
`timescale 1ns/1ps
module ddrio_mem_model
  import ddrio_pkg::*;
(
  // clock and burst control
  input wire logic sys_clk,
  input wire logic go,
  input wire logic slow,
  input wire logic [DQ_W-1:0] rise_w,
  input wire logic [DQ_W-1:0] fall_w,
  // memory pins
  output logic [DQ_W-1:0] dq,
  output logic [LANES-1:0] dqs,
  input wire logic [DQ_W-1:0] dq_o,
  input wire logic [LANES-1:0] dqs_o,
  input wire logic [LANES-1:0] dqs_oe,
  // words taken on write strobe edges
  output logic [DQ_W-1:0] got_rise,
  output logic [DQ_W-1:0] got_fall
);
  logic prev_q;

  // ----------------------------------------
  // read burst
  // ----------------------------------------
  // edge-aligned read strobe
  initial begin
    dq = '0;
    dqs = '0;
    forever begin
      @(posedge go);
      #(3 + 13 * slow);
      dq = rise_w;
      dqs = '1;
      #40;
      dq = fall_w;
      dqs = '0;
      #40;
      dq = ~fall_w; // hold time over: never leave the last word showing
    end
  end

  // ----------------------------------------
  // write capture
  // ----------------------------------------
  // sample on both strobe edges
  always @(posedge sys_clk) begin
    prev_q <= dqs_o[0];
    if (dqs_oe[0] && dqs_o[0] && !prev_q) got_rise <= dq_o;
    if (dqs_oe[0] && !dqs_o[0] && prev_q) got_fall <= dq_o;
  end
endmodule

// ---- dv/ddrio_tb.sv ----
/*
  Self-checking bench for the DDR I/O datapath with a memory model on its pins.
  Assumes a 5 ns system clock and an 80 ns read strobe from the model.
*/
`timescale 1ns/1ps
module testbench;
  import ddrio_pkg::*;
  logic sys_clk = 0, srst = 1, wr_valid = 0, cmd_valid = 0, rd_en = 1, rd_phase_sel = 0;
  logic rd_ready = 0, go = 0, slow = 0;
  logic [DQ_W-1:0] wr_rise = '0, wr_fall = '0, m_rise = '0, m_fall = '0;
  logic [LANES-1:0] wr_mask_rise = '0, wr_mask_fall = '0;
  logic [CMD_W-1:0] cmd_in = '0;
  logic [ADDR_W-1:0] addr_in = '0;
  logic wr_ready_q, cmd_ready_q, rd_valid, rd_overrun_q, mem_ck_q, mem_ck_n_q;
  logic [DQ_W-1:0] rd_rise, rd_fall, dq_i, dq_o_q, dq_oe_q, got_rise, got_fall;
  logic [CMD_W-1:0] cmd_o_q;
  logic [ADDR_W-1:0] addr_o_q;
  logic [LANES-1:0] dm_q, dqs_i, dqs_o_q, dqs_oe_q;
  int fail_count = 0, n_checks = 0, cyc = 0;

  // ----------------------------------------
  // clock, design and memory
  // ----------------------------------------
  always #2.5 sys_clk = ~sys_clk;

  ddrio_top i_dut (.sys_clk(sys_clk), .srst(srst), .wr_valid(wr_valid),
    .wr_ready_q(wr_ready_q), .wr_rise(wr_rise), .wr_fall(wr_fall),
    .wr_mask_rise(wr_mask_rise), .wr_mask_fall(wr_mask_fall), .cmd_valid(cmd_valid),
    .cmd_ready_q(cmd_ready_q), .cmd_in(cmd_in), .addr_in(addr_in), .rd_en(rd_en),
    .rd_phase_sel(rd_phase_sel), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_rise(rd_rise), .rd_fall(rd_fall), .rd_overrun_q(rd_overrun_q),
    .mem_ck_q(mem_ck_q), .mem_ck_n_q(mem_ck_n_q), .cmd_o_q(cmd_o_q), .addr_o_q(addr_o_q),
    .dm_q(dm_q), .dq_i(dq_i), .dq_o_q(dq_o_q), .dq_oe_q(dq_oe_q), .dqs_i(dqs_i),
    .dqs_o_q(dqs_o_q), .dqs_oe_q(dqs_oe_q));

  ddrio_mem_model i_mem (.sys_clk(sys_clk), .go(go), .slow(slow), .rise_w(m_rise),
    .fall_w(m_fall), .dq(dq_i), .dqs(dqs_i), .dq_o(dq_o_q), .dqs_o(dqs_o_q),
    .dqs_oe(dqs_oe_q), .got_rise(got_rise), .got_fall(got_fall));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic cmp(input string what, input logic [DQ_W-1:0] exp,
                     input logic [DQ_W-1:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one strobe burst from the memory, launched off the clock edge
  task automatic burst(input logic sl, input logic [DQ_W-1:0] r, input logic [DQ_W-1:0] f);
    @(posedge sys_clk);
    slow <= sl;
    m_rise <= r;
    m_fall <= f;
    go <= 1;
    @(posedge sys_clk);
    go <= 0;
  endtask

  task automatic pop();
    @(posedge sys_clk);
    rd_ready <= 1;
    @(posedge sys_clk);
    rd_ready <= 0;
    #1;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic reset_values();
    cmp("mem_ck", 1'b0, mem_ck_q);
    cmp("mem_ck_n", 1'b1, mem_ck_n_q);
    cmp("cmd_o", CMD_NOP, cmd_o_q);
    cmp("dq_oe", '0, dq_oe_q);
    cmp("dqs_oe", '0, dqs_oe_q);
    cmp("dm", '0, dm_q);
    cmp("rd_valid", 1'b0, rd_valid);
  endtask

  task automatic do_write(input logic [DQ_W-1:0] r, input logic [DQ_W-1:0] f,
                          input logic [LANES-1:0] mr, input logic [LANES-1:0] mf);
    int oe_n;
    logic prev;
    logic pck;
    oe_n = 0;
    prev = 0;
    pck = 0;
    do begin
      @(posedge sys_clk);
      #1;
    end while (wr_ready_q !== 1'b1);
    @(posedge sys_clk);
    wr_valid <= 1;
    wr_rise <= r;
    wr_fall <= f;
    wr_mask_rise <= mr;
    wr_mask_fall <= mf;
    @(posedge sys_clk);
    wr_valid <= 0;
    repeat (50) begin
      @(posedge sys_clk);
      #1;
      if (dq_oe_q[0] === 1'b1) oe_n++;
      if (dqs_o_q[0] === 1'b1 && !prev) begin
        cmp("mem_ck at strobe rise", 1'b1, mem_ck_q);
        cmp("mem_ck low before strobe rise", 1'b0, pck);
        cmp("mask first half", mr, dm_q);
      end
      if (dqs_o_q[0] === 1'b0 && prev) cmp("mask second half", mf, dm_q);
      prev = dqs_o_q[0];
      pck = mem_ck_q;
    end
    cmp("data enable cycles", 16, oe_n);
    cmp("rise word at strobe", r, got_rise);
    cmp("fall word at strobe", f, got_fall);
  endtask

  task automatic do_cmd(input logic [CMD_W-1:0] c, input logic [ADDR_W-1:0] a);
    int n;
    n = 0;
    while (cmd_ready_q !== 1'b1) begin
      @(posedge sys_clk);
      #1;
    end
    // ready stands high here, so the edge after raising valid takes the command
    @(posedge sys_clk);
    cmd_valid <= 1;
    cmd_in <= c;
    addr_in <= a;
    @(posedge sys_clk);
    cmd_valid <= 0;
    repeat (20) begin
      @(posedge sys_clk);
      #1;
      if (cmd_o_q !== c) continue;
      n++;
      if (n == 1) begin
        cmp("mem_ck at command", 1'b0, mem_ck_q);
        cmp("clock pair", 1'b1, mem_ck_n_q);
        cmp("address", a, addr_o_q);
      end
    end
    repeat (20) begin
      @(posedge sys_clk);
      #1;
      if (cmd_o_q === c) n++;
    end
    cmp("command cycles", 16, n);
  endtask

  task automatic do_read(input logic sel, input logic sl, input logic [DQ_W-1:0] r,
                         input logic [DQ_W-1:0] f);
    int n;
    n = 0;
    @(posedge sys_clk);
    rd_phase_sel <= sel;
    burst(sl, r, f);
    while (rd_valid !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    cmp("read rise word", r, rd_rise);
    cmp("read fall word", f, rd_fall);
    pop();
  endtask

  // a full strobe burst with capture disabled must deliver nothing
  task automatic read_disabled();
    @(posedge sys_clk);
    rd_en <= 0;
    burst(0, 40'h7777_7777_77, 40'h8888_8888_88);
    repeat (40) @(posedge sys_clk);
    #1;
    cmp("read while disabled", 1'b0, rd_valid);
    @(posedge sys_clk);
    rd_en <= 1;
  endtask

  task automatic fill_and_drain();
    burst(0, 40'h1111_1111_11, 40'h2222_2222_22);
    repeat (30) @(posedge sys_clk);
    burst(0, 40'h3333_3333_33, 40'h4444_4444_44);
    repeat (30) @(posedge sys_clk);
    burst(0, 40'h5555_5555_55, 40'h6666_6666_66);
    repeat (30) @(posedge sys_clk);
    #1;
    cmp("overrun", 1'b1, rd_overrun_q);
    cmp("head rise", 40'h1111_1111_11, rd_rise);
    pop();
    cmp("second fall", 40'h4444_4444_44, rd_fall);
    pop();
    cmp("drained", 1'b0, rd_valid);
  endtask

  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    reset_values();
    @(posedge sys_clk);
    srst <= 0;
    do_write(40'h0123_4567_89, 40'hfedc_ba98_76, 5'h15, 5'h0a);
    do_write(40'ha5a5_a5a5_a5, 40'h5a5a_5a5a_5a, 5'h1f, 5'h00);
    do_cmd(3'h3, 13'h1abc);
    do_read(0, 0, 40'hc3c3_1234_56, 40'h3c3c_abcd_ef);
    do_read(1, 1, 40'h0f0f_0f0f_0f, 40'hf0f0_f0f0_f0);
    read_disabled();
    fill_and_drain();
    give_verdict();
  end

  // ceiling well above the roughly 350 cycles the scenarios need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      give_verdict();
    end
  end
endmodule
